// ==== src/dsc_channel.sv ====
// Contract
// - When the live count reaches zero, restore it from the size shadow.
// - In single modes, enable falling reloads the count from the shadow.
// - The count register is updated when each transaction completes.
// - A count write while idle and disabled becomes the programmed count.
// - A count write while active changes the live counter immediately.
// - Channel transfers never modify any channel's address registers.
// - Transfers started inside a CPU flag read-modify-write keep set flags.
// - An interrupted 20-bit address write may leave an unpredictable value.
// - The inhibit bit holds transfers off during CPU read-modify-writes.
`timescale 1ns/10ps
module dsc_channel
    import dsc_pkg::*;
(
    // Clock and reset.
    input  wire logic                  CLK_SYS,
    input  wire logic                  RESETN,
    // Configuration port (CPU or debug port only).
    input  wire dsc_cfg_t              CFG,
    input  wire logic                  REPEAT_MODE,
    input  wire logic                  RMW_TRANSFER_INHIBIT,
    input  wire logic                  CPU_RMW,
    // Trigger and source data.
    input  wire logic                  TRIGGER,
    input  wire logic [DSC_DATA_W-1:0] SRC_DATA,
    // Destination side, drained through the FIFO.
    output logic                       DST_VALID,
    input  wire logic                  DST_READY,
    output logic [DSC_DATA_W-1:0]      DST_DATA,
    output logic [DSC_ADDR_W-1:0]      DST_ADDR,
    // Status.
    output dsc_stat_t                  STATUS,
    output logic                       XFER_DONE
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // The shadow keeps the programmed size; count is the live counter that
    // software sees. cur_dst is the address of the next word to be taken.
    typedef struct packed {
        dsc_state_t            fsm;
        logic                  enable;
        logic                  busy;
        logic [DSC_CNT_W-1:0]  shadow;
        logic [DSC_CNT_W-1:0]  count;
        logic [DSC_ADDR_W-1:0] src;
        logic [DSC_ADDR_W-1:0] dst;
        logic [DSC_ADDR_W-1:0] cur_dst;
        logic                  done;
        logic                  ovalid;
        logic [DSC_DATA_W-1:0] odata;
        logic [DSC_ADDR_W-1:0] oaddr;
    } dsc_ch_st_t;

    dsc_ch_st_t            st;
    dsc_ch_st_t            next_st;
    logic                  fifo_in_ready;
    logic                  fifo_out_valid;
    logic                  fifo_out_ready;
    dsc_word_t             fifo_in_word;
    dsc_word_t             fifo_out_word;
    logic [DSC_ADDR_W-1:0] addr_wr_val;
    logic                  go;
    logic                  hold;

    // ------------------------------------------------------------------
    // Data buffer
    // ------------------------------------------------------------------
    // The output stage pulls from the FIFO whenever it is free or emptying.
    assign fifo_out_ready = !st.ovalid || DST_READY;

    // Each word travels with its own destination address, so the address shown
    // beside a word stays right however far the buffer has filled up.
    assign fifo_in_word.addr = st.cur_dst;
    assign fifo_in_word.data = SRC_DATA;

    dsc_fifo #(
        .WIDTH ($bits(dsc_word_t)),
        .DEPTH (DSC_FIFO_DEPTH),
        .AW    (DSC_FIFO_AW)
    ) u_fifo (
        .clk       (CLK_SYS),
        .resetn    (RESETN),
        .in_valid  (go),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_word),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_word)
    );

    // ------------------------------------------------------------------
    // Transaction gate and address write value
    // ------------------------------------------------------------------
    // A transaction is held off during a CPU read-modify-write when inhibited,
    // so a flag write-back is never split by a transfer.
    assign hold = RMW_TRANSFER_INHIBIT && CPU_RMW;
    assign go   = (st.fsm == DSC_XFER) && !hold && fifo_in_ready;

    // A word write clears the upper address bits; a wide write is stored as
    // written, even when it lands in the same cycle as a transaction.
    assign addr_wr_val = CFG.wide ? CFG.addr_val : (CFG.addr_val & DSC_WORD_MASK);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Transfers feed the FIFO and update count and enable; addresses change from CFG alone.
    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        // Sequencer: wait for trigger, move one word per transaction.
        unique case (st.fsm)
            DSC_IDLE: begin
                // Nothing moves until the enable bit is set.
            end
            DSC_WAIT: begin
                if (TRIGGER && st.enable) begin
                    next_st.fsm     = DSC_XFER;
                    next_st.cur_dst = st.dst;
                end
            end
            DSC_XFER: begin
                if (go) begin
                    next_st.cur_dst = st.cur_dst + DSC_ADDR_ONE;
                    // Last transaction: restore the count, then end or rearm.
                    if (st.count == DSC_CNT_ONE) begin
                        next_st.count = st.shadow;
                        next_st.done  = 1'b1;
                        if (REPEAT_MODE && st.enable) begin
                            next_st.fsm = DSC_WAIT;
                        end else begin
                            next_st.fsm    = DSC_IDLE;
                            next_st.enable = 1'b0;
                        end
                    end else begin
                        next_st.count = st.count - DSC_CNT_ONE;
                    end
                end
            end
            default: begin
                next_st.fsm = DSC_IDLE;
            end
        endcase
        // Enable bit and its falling edge; placed after the sequencer so a
        // single-mode disable in the cycle of a transaction still reloads the count.
        if (CFG.en_wr) begin
            if (st.enable && !CFG.en_val) begin
                next_st.enable = 1'b0;
                next_st.fsm    = DSC_IDLE;
                if (!REPEAT_MODE) begin
                    next_st.count = st.shadow;
                end
            end else if (!st.enable && CFG.en_val) begin
                next_st.enable = 1'b1;
                next_st.fsm    = DSC_WAIT;
            end
        end
        // Count writes: idle and disabled sets the programmed size; otherwise
        // the live counter changes at once and runs on until it hits zero.
        if (CFG.cnt_wr) begin
            next_st.count = CFG.cnt_val;
            if (st.fsm == DSC_IDLE && !st.enable) begin
                next_st.shadow = CFG.cnt_val;
            end
        end
        // Address writes come only from the configuration port; transfers have
        // no path into any channel's address registers.
        if (CFG.src_wr) begin
            next_st.src = addr_wr_val;
        end
        if (CFG.dst_wr) begin
            next_st.dst = addr_wr_val;
        end
        // Output stage.
        if (fifo_out_ready) begin
            next_st.ovalid = fifo_out_valid;
            if (fifo_out_valid) begin
                next_st.odata = fifo_out_word.data;
                next_st.oaddr = fifo_out_word.addr;
            end
        end
        // Busy is kept as a flop of its own so that the status output is
        // registered and follows the sequencer state of the same cycle.
        next_st.busy = (next_st.fsm != DSC_IDLE);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // All control state returns to idle, disabled and zero on reset.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            st         <= '0;
            st.fsm     <= DSC_IDLE;
            st.shadow  <= DSC_CNT_ZERO;
            st.count   <= DSC_CNT_ZERO;
            st.src     <= DSC_ADDR_RST;
            st.dst     <= DSC_ADDR_RST;
            st.cur_dst <= DSC_ADDR_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Outputs straight from the state register.
    assign DST_VALID     = st.ovalid;
    assign DST_DATA      = st.odata;
    assign DST_ADDR      = st.oaddr;
    assign XFER_DONE     = st.done;
    assign STATUS.enable = st.enable;
    assign STATUS.busy   = st.busy;
    assign STATUS.count  = st.count;
    assign STATUS.src    = st.src;
    assign STATUS.dst    = st.dst;
endmodule : dsc_channel

// ==== src/dsc_fifo.sv ====
`timescale 1ns/10ps
module dsc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             resetn,
    // Fill side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } dsc_fifo_st_t;

    dsc_fifo_st_t     st;
    dsc_fifo_st_t     next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    // Handshakes and flags follow the occupancy count.
    assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data  = mem[st.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Next pointer and count values.
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wp = st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Storage array, written on each accepted word.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[st.wp] <= in_data;
        end
    end
endmodule : dsc_fifo

// ==== src/dsc_pkg.sv ====
package dsc_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int          DSC_CNT_W      = 16;
    localparam int          DSC_ADDR_W     = 20;
    localparam int          DSC_DATA_W     = 16;
    localparam int          DSC_FIFO_DEPTH = 16;
    localparam int          DSC_FIFO_AW    = 4;
    localparam logic [15:0] DSC_CNT_ZERO   = 16'h0000;
    localparam logic [15:0] DSC_CNT_ONE    = 16'h0001;
    localparam logic [19:0] DSC_ADDR_RST   = 20'h00000;
    localparam logic [19:0] DSC_ADDR_ONE   = 20'h00001;
    localparam logic [19:0] DSC_WORD_MASK  = 20'h0FFFF;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DSC_IDLE  = 2'b00,
        DSC_WAIT  = 2'b01,
        DSC_XFER  = 2'b10
    } dsc_state_t;

    // Write from the CPU or the debug port to one channel's configuration.
    typedef struct packed {
        logic                  en_wr;    // Write of channel_enable_bit.
        logic                  en_val;
        logic                  cnt_wr;   // Write of transfer_count_reg.
        logic [DSC_CNT_W-1:0]  cnt_val;
        logic                  src_wr;   // Write of source_address_reg.
        logic                  dst_wr;   // Write of destination_address_reg.
        logic                  wide;     // 1: 20-bit write, 0: 16-bit word write.
        logic [DSC_ADDR_W-1:0] addr_val;
    } dsc_cfg_t;

    // Observed status of the channel.
    typedef struct packed {
        logic                  enable;
        logic                  busy;
        logic [DSC_CNT_W-1:0]  count;
        logic [DSC_ADDR_W-1:0] src;
        logic [DSC_ADDR_W-1:0] dst;
    } dsc_stat_t;

    // One word in flight, carried through the buffer with its destination.
    typedef struct packed {
        logic [DSC_ADDR_W-1:0] addr;
        logic [DSC_DATA_W-1:0] data;
    } dsc_word_t;

endpackage : dsc_pkg

// ==== tb/dsc_channel_asserts.sv ====
`timescale 1ns/10ps
module dsc_channel_asserts
    import dsc_pkg::*;
(
    // Clock and reset.
    input wire logic                  CLK_SYS,
    input wire logic                  RESETN,
    // Inputs.
    input wire dsc_cfg_t              CFG,
    input wire logic                  REPEAT_MODE,
    input wire logic                  RMW_TRANSFER_INHIBIT,
    input wire logic                  CPU_RMW,
    input wire logic                  DST_READY,
    // Outputs.
    input wire logic                  DST_VALID,
    input wire logic [DSC_DATA_W-1:0] DST_DATA,
    input wire logic [DSC_ADDR_W-1:0] DST_ADDR,
    input wire dsc_stat_t             STATUS,
    input wire logic                  XFER_DONE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    logic [15:0] shadow;
    // Keeps the programmed count, which only an idle, disabled write changes.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) shadow <= 16'h0000;
        else if (CFG.cnt_wr && !STATUS.busy && !STATUS.enable) shadow <= CFG.cnt_val;
    end
    AST_DONE_RELOAD: assert property (XFER_DONE |-> STATUS.count == shadow)
        else $error("count not restored at transfer end");
    AST_DISABLE_RELOAD: assert property ((CFG.en_wr && !CFG.en_val && STATUS.enable
        && !REPEAT_MODE && !CFG.cnt_wr) |=> (STATUS.count == shadow && !STATUS.busy))
        else $error("count not reloaded on disable");
    AST_DONE_PULSE: assert property (XFER_DONE |=> !XFER_DONE)
        else $error("done pulse too long");
    AST_IDLE_WRITE: assert property ((CFG.cnt_wr && !STATUS.busy && !STATUS.enable)
        |=> STATUS.count == $past(CFG.cnt_val)) else $error("idle count write lost");
    AST_LIVE_WRITE: assert property ((CFG.cnt_wr && STATUS.busy)
        |=> STATUS.count == $past(CFG.cnt_val)) else $error("live count write lost");
    AST_NO_SELF_MODIFY: assert property ((!CFG.src_wr && !CFG.dst_wr)
        |=> $stable(STATUS.src) && $stable(STATUS.dst)) else $error("address changed");
    AST_WORD_MASK: assert property ((CFG.src_wr && !CFG.wide)
        |=> STATUS.src == ($past(CFG.addr_val) & DSC_WORD_MASK)) else $error("word write");
    AST_INHIBIT_HOLD: assert property ((RMW_TRANSFER_INHIBIT && CPU_RMW && STATUS.busy
        && !CFG.cnt_wr && !CFG.en_wr) |=> $stable(STATUS.count)) else $error("not held");
    AST_DEC_ONE: assert property ((STATUS.busy && !CFG.cnt_wr && !CFG.en_wr)
        |=> (XFER_DONE || $stable(STATUS.count) || STATUS.count == $past(STATUS.count) - 16'h0001))
        else $error("count step not one");
    AST_STALL_HOLD: assert property ((DST_VALID && !DST_READY)
        |=> DST_VALID && $stable(DST_DATA) && $stable(DST_ADDR))
        else $error("word dropped under stall");
    COV_DONE: cover property (XFER_DONE);
    COV_HELD: cover property (RMW_TRANSFER_INHIBIT && CPU_RMW && STATUS.busy);
    COV_STALL: cover property (DST_VALID && !DST_READY);
    COV_DISABLE: cover property (CFG.en_wr && !CFG.en_val && STATUS.enable && !REPEAT_MODE);
endmodule : dsc_channel_asserts

bind dsc_channel dsc_channel_asserts u_asrt (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .CFG(CFG),
    .REPEAT_MODE(REPEAT_MODE), .RMW_TRANSFER_INHIBIT(RMW_TRANSFER_INHIBIT), .CPU_RMW(CPU_RMW),
    .DST_READY(DST_READY), .DST_VALID(DST_VALID), .DST_DATA(DST_DATA),
    .DST_ADDR(DST_ADDR), .STATUS(STATUS),
    .XFER_DONE(XFER_DONE));

// ==== tb/dsc_sink_model.sv ====
`timescale 1ns/10ps
module dsc_sink_model (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic resetn,
    // Word handshake.
    input  wire logic valid,
    input  wire logic stall,
    output logic      ready,
    output int        words
);
    // The sink refuses words for as long as the bench asks it to stall.
    assign ready = !stall;
    // Counts every word accepted by the sink.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) words <= 0;
        else if (valid && ready) words <= words + 1;
    end
endmodule : dsc_sink_model

// ==== tb/tb_dma_channel_size_counter.sv ====
`timescale 1ns/10ps
module tb_dma_channel_size_counter;
    import dsc_pkg::*;
    logic clk_sys, resetn, rep, inh, rmw, trig, dvalid, dready, done, stall;
    logic [15:0] ddata;
    logic [19:0] daddr;
    dsc_cfg_t    cfg;
    dsc_stat_t   st;
    int          mismatches, check_count, cycles, words, w0;
    dsc_channel uut (.CLK_SYS(clk_sys), .RESETN(resetn), .CFG(cfg), .REPEAT_MODE(rep),
        .RMW_TRANSFER_INHIBIT(inh), .CPU_RMW(rmw), .TRIGGER(trig), .SRC_DATA(16'hA5C3),
        .DST_VALID(dvalid), .DST_READY(dready), .DST_DATA(ddata), .DST_ADDR(daddr),
        .STATUS(st), .XFER_DONE(done));
    dsc_sink_model sink (.clk(clk_sys), .resetn(resetn), .valid(dvalid), .stall(stall),
        .ready(dready), .words(words));
    // Makes the 10 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    task wr(input dsc_cfg_t c);
        @(negedge clk_sys) cfg = c;
        @(negedge clk_sys) cfg = '0;
    endtask : wr
    task set_cnt(input logic [15:0] v);
        wr({3'b001, v, 23'h0});
    endtask : set_cnt
    task set_en(input logic v);
        wr({1'b1, v, 40'h0});
    endtask : set_en
    task start(input logic [15:0] n);
        set_cnt(n);
        set_en(1'b1);
        @(negedge clk_sys) trig = 1'b1;
        @(negedge clk_sys) trig = 1'b0;
    endtask : start
    task wait_done(input int n);
        for (int i = 0; i < n && done !== 1'b1; i++) @(negedge clk_sys);
        chk("done", done, 1'b1);
    endtask : wait_done
    task t_addr();
        wr({19'h0, 3'b100, 20'hABCDE});
        chk("src", st.src, 20'h0BCDE);
        wr({19'h0, 3'b011, 20'hABCDE});
        chk("dst", st.dst, 20'hABCDE);
    endtask : t_addr
    task t_fill();
        w0 = words;
        stall = 1'b1;
        start(16'h0014);
        repeat (40) @(negedge clk_sys);
        chk("busy", st.busy, 1'b1);
        chk("valid", dvalid, 1'b1);
        chk("data", ddata, 16'hA5C3);
        chk("addr", daddr, 20'hABCDE);
        stall = 1'b0;
        wait_done(40);
        chk("count", st.count, 16'h0014);
        repeat (25) @(negedge clk_sys);
        chk("words", words - w0, 20);
        chk("last addr", daddr, 20'hABCF1);
        chk("enable", st.enable, 1'b0);
    endtask : t_fill
    task t_inhibit();
        inh = 1'b1;
        rmw = 1'b1;
        start(16'h0002);
        repeat (6) @(negedge clk_sys);
        chk("held", st.count, 16'h0002);
        rmw = 1'b0;
        wait_done(10);
        inh = 1'b0;
    endtask : t_inhibit
    task t_live();
        start(16'h000C);
        set_cnt(16'h0001);
        wait_done(2);
        chk("shadow", st.count, 16'h000C);
    endtask : t_live
    task t_disable();
        inh = 1'b1;
        rmw = 1'b1;
        start(16'h0005);
        rmw = 1'b0;
        repeat (2) @(negedge clk_sys);
        rmw = 1'b1;
        chk("dec", st.count, 16'h0003);
        set_en(1'b0);
        chk("reload", st.count, 16'h0005);
        chk("busy", st.busy, 1'b0);
        {inh, rmw} = 2'b00;
    endtask : t_disable
    task t_repeat();
        rep = 1'b1;
        start(16'h0002);
        wait_done(6);
        chk("enable", st.enable, 1'b1);
        set_en(1'b0);
        rep = 1'b0;
        chk("src", st.src, 20'h0BCDE);
    endtask : t_repeat
    // Counts cycles and cuts a hang short.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            results();
        end
    end
    task results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    // Main sequence.
    initial begin
        {resetn, rep, inh, rmw, trig, stall} = 6'h00;
        cfg = '0;
        repeat (6) @(negedge clk_sys);
        resetn = 1'b1;
        chk("rst", st.count, 16'h0000);
        t_addr();
        $display("test addr done");
        t_fill();
        $display("test fill done");
        t_inhibit();
        $display("test inhibit done");
        t_live();
        $display("test live done");
        t_disable();
        $display("test disable done");
        t_repeat();
        $display("test repeat done");
        results();
    end
endmodule : tb_dma_channel_size_counter
